//--- hw/ident_regs_pkg.sv
// package: command codes, fixed values and carrier types of the identification
// and scratchpad register bank
// assumes: a command decoder presents one command code per access
package ident_regs_pkg;

	localparam logic [7:0]  CMD_BUS_FEATURE     = 8'h19;
	localparam logic [7:0]  CMD_PROTOCOL_REV    = 8'h98;
	localparam logic [7:0]  CMD_TOOL_WORD_A     = 8'hB0;
	localparam logic [7:0]  CMD_TOOL_WORD_B     = 8'hB1;
	localparam logic [7:0]  CMD_OEM_WORD        = 8'hB2;
	localparam logic [7:0]  CMD_SCRATCH_PAGED   = 8'hB3;
	localparam logic [7:0]  CMD_SCRATCH_UNPAGED = 8'hB4;
	localparam logic [7:0]  CMD_MAKER_INFO      = 8'hB6;
	localparam logic [7:0]  CMD_MAKER_RSVD      = 8'hBC;
	localparam logic [7:0]  CMD_MAKER_ID        = 8'hE7;
	localparam logic [7:0]  CMD_FACTORY_LOT     = 8'hE8;

	localparam logic        FEAT_PEC            = 1'h1;
	localparam logic [1:0]  FEAT_SCL_MAX        = 2'h1;
	localparam logic        FEAT_ALERT          = 1'h1;
	localparam logic [3:0]  FEAT_RESERVED       = 4'h0;
	localparam logic [7:0]  PROTOCOL_REV_VALUE  = 8'h11;
	localparam int          INFO_ECC_BIT        = 5;
	localparam logic [15:0] SCRATCH_RESET       = 16'h0000;
	localparam logic [15:0] WORD_RESET          = 16'h0000;
	localparam int          NUM_PAGES           = 2;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic [7:0]  code;
		logic [15:0] wdata;
	} host_req_type;

	typedef struct packed {
		logic        valid;
		logic        hit;
		logic [15:0] rdata;
	} host_rsp_type;

	typedef struct packed {
		logic        load;
		logic        ecc_clean;
		logic [15:0] tool_word_a;
		logic [15:0] tool_word_b0;
		logic [15:0] tool_word_b1;
		logic [15:0] oem_word;
		logic [15:0] scratch_paged0;
		logic [15:0] scratch_paged1;
		logic [15:0] scratch_unpaged;
		logic [7:0]  lot0;
		logic [7:0]  lot1;
	} nvm_image_type;

endpackage

//--- hw/pmbus_ident_scratchpad_regs.sv
// pmbus identification, information and user scratchpad register bank
// assumes: command decoder on sys_clk, nvm engine presents image with a load pulse
//
// What this block does
// - feature byte reads 0xB0, low nibble zero
// - feature bit 7 set: pec supported
// - feature bits 6:5 are 01: 400kHz
// - feature bit 4 set: alert output present
// - pec-required status on separate config bit
// - revision byte hard-wired to 0x11
// - maker identifier word always fixed
// - paged lot byte from nvm, read-only
// - info refreshed on reset, restore, bulk read
// - info bit 5 zero when ecc corrected
// - 0xB0 unpaged, 0xB1 paged tool words
// - scratch words 0xB3 paged, 0xB4 unpaged
`timescale 1ns/1ps
`default_nettype none

module pmbus_ident_scratchpad_regs #(
	parameter logic [15:0] MAKER_ID = 16'h5A5A // arbitrary value
) (
	input  wire logic                          sys_clk,
	input  wire logic                          resetn,
	input  wire ident_regs_pkg::host_req_type  host_req,
	input  wire logic                          page_sel,
	input  wire logic                          pec_required,
	input  wire ident_regs_pkg::nvm_image_type nvm_image,
	output var  ident_regs_pkg::host_rsp_type  host_rsp,
	output logic                               pec_required_status
);
	import ident_regs_pkg::*;

	typedef struct packed {
		host_rsp_type rsp;
		logic         pec_status;
		logic         ecc_clean;
		logic [15:0]  tool_word_a;
		logic [15:0]  oem_word;
		logic [15:0]  scratch_unpaged;
		logic [NUM_PAGES-1:0][15:0] tool_word_b;
		logic [NUM_PAGES-1:0][15:0] scratch_paged;
		logic [NUM_PAGES-1:0][15:0] maker_rsvd;
		logic [NUM_PAGES-1:0][7:0]  lot;
	} state_type;

	state_type state_q;
	state_type state_d;
	logic [7:0] feature_byte;
	logic [15:0] info_word;
	logic pg;

	assign feature_byte = {FEAT_PEC, FEAT_SCL_MAX, FEAT_ALERT, FEAT_RESERVED};

	always_comb begin
		info_word = 16'h0000;
		info_word[INFO_ECC_BIT] = state_q.ecc_clean;
	end

	assign pg = page_sel;

	always_comb begin
		state_d = state_q;
		state_d.rsp = '0;
		state_d.pec_status = pec_required;
		// nvm image load after restore or bulk read
		if (nvm_image.load) begin
			state_d.ecc_clean          = nvm_image.ecc_clean;
			state_d.tool_word_a        = nvm_image.tool_word_a;
			state_d.tool_word_b[0]     = nvm_image.tool_word_b0;
			state_d.tool_word_b[1]     = nvm_image.tool_word_b1;
			state_d.oem_word           = nvm_image.oem_word;
			state_d.scratch_paged[0]   = nvm_image.scratch_paged0;
			state_d.scratch_paged[1]   = nvm_image.scratch_paged1;
			state_d.scratch_unpaged    = nvm_image.scratch_unpaged;
			state_d.lot[0]             = nvm_image.lot0;
			state_d.lot[1]             = nvm_image.lot1;
		end
		if (host_req.valid) begin
			state_d.rsp.valid = 1'b1;
			state_d.rsp.hit   = 1'b1;
			case (host_req.code)
				CMD_BUS_FEATURE: begin
					state_d.rsp.rdata = {8'h00, feature_byte};
				end
				CMD_PROTOCOL_REV: begin
					state_d.rsp.rdata = {8'h00, PROTOCOL_REV_VALUE};
				end
				CMD_MAKER_ID: begin
					state_d.rsp.rdata = MAKER_ID;
				end
				CMD_FACTORY_LOT: begin
					state_d.rsp.rdata = {8'h00, state_q.lot[pg]};
				end
				CMD_MAKER_INFO: begin
					state_d.rsp.rdata = info_word;
				end
				CMD_TOOL_WORD_A: begin
					state_d.rsp.rdata = state_q.tool_word_a;
					if (host_req.write) begin
						state_d.tool_word_a = host_req.wdata;
					end
				end
				CMD_TOOL_WORD_B: begin
					state_d.rsp.rdata = state_q.tool_word_b[pg];
					if (host_req.write) begin
						state_d.tool_word_b[pg] = host_req.wdata;
					end
				end
				CMD_OEM_WORD: begin
					state_d.rsp.rdata = state_q.oem_word;
					if (host_req.write) begin
						state_d.oem_word = host_req.wdata;
					end
				end
				CMD_SCRATCH_PAGED: begin
					state_d.rsp.rdata = state_q.scratch_paged[pg];
					if (host_req.write) begin
						state_d.scratch_paged[pg] = host_req.wdata;
					end
				end
				CMD_SCRATCH_UNPAGED: begin
					state_d.rsp.rdata = state_q.scratch_unpaged;
					if (host_req.write) begin
						state_d.scratch_unpaged = host_req.wdata;
					end
				end
				CMD_MAKER_RSVD: begin
					state_d.rsp.rdata = state_q.maker_rsvd[pg];
					if (host_req.write) begin
						state_d.maker_rsvd[pg] = host_req.wdata;
					end
				end
				default: begin
					state_d.rsp.hit = 1'b0;
				end
			endcase
		end
	end

	// power-on values; info refresh at reset happens here too
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= '0;
			state_q.ecc_clean <= 1'b1;
			state_q.scratch_unpaged <= SCRATCH_RESET;
			state_q.scratch_paged <= {NUM_PAGES{SCRATCH_RESET}};
			state_q.tool_word_a <= WORD_RESET;
		end else begin
			state_q <= state_d;
		end
	end

	assign host_rsp = state_q.rsp;
	assign pec_required_status = state_q.pec_status;

endmodule // pmbus_ident_scratchpad_regs

`default_nettype wire

//--- test/ident_regs_monitor.sv
// checker: port-level checks of the ident register bank
// assumes: bound to the top module, one sys_clk domain
`timescale 1ns/1ps
`default_nettype none
module ident_regs_monitor import ident_regs_pkg::*; #(
	parameter logic [15:0] MAKER_ID = 16'h5A5A
) (
	input wire logic                          sys_clk,
	input wire logic                          resetn,
	input wire ident_regs_pkg::host_req_type  host_req,
	input wire logic                          page_sel,
	input wire logic                          pec_required,
	input wire ident_regs_pkg::nvm_image_type nvm_image,
	input wire ident_regs_pkg::host_rsp_type  host_rsp,
	input wire logic                          pec_required_status
);
	logic        rq;
	logic [7:0]  cd;
	logic [15:0] d;
	assign rq = host_req.valid;
	assign cd = host_req.code;
	assign d = host_rsp.rdata;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	property p_rsp; 1 |=> host_rsp.valid == $past(rq); endproperty
	a_rsp: assert property (p_rsp) else $error("answer timing");
	property p_feat; rq && cd == CMD_BUS_FEATURE |=> d == 16'h00B0; endproperty
	a_feat: assert property (p_feat) else $error("feature byte");
	property p_cap; rq && cd == CMD_BUS_FEATURE |=> d[7:4] == 4'hB; endproperty
	a_cap: assert property (p_cap) else $error("feature bits");
	property p_pecst; $changed(pec_required) |=> pec_required_status == $past(pec_required); endproperty
	a_pecst: assert property (p_pecst) else $error("pec status");
	property p_rev; rq && cd == CMD_PROTOCOL_REV |=> d == 16'h0011; endproperty
	a_rev: assert property (p_rev) else $error("revision");
	property p_id; rq && cd == CMD_MAKER_ID |=> d == MAKER_ID; endproperty
	a_id: assert property (p_id) else $error("maker id");
	property p_info; rq && cd == CMD_MAKER_INFO |=> (d & 16'hFFDF) == 16'h0000; endproperty
	a_info: assert property (p_info) else $error("info reserved");
	property p_ld; nvm_image.load ##1 rq && cd == CMD_MAKER_INFO |=> d[5] == $past(nvm_image.ecc_clean, 2); endproperty
	a_ld: assert property (p_ld) else $error("info refresh");
endmodule // ident_regs_monitor
bind pmbus_ident_scratchpad_regs ident_regs_monitor #(.MAKER_ID(MAKER_ID)) mon_u (.*);
`default_nettype wire

//--- test/nvm_engine_model.sv
// model: nvm engine presenting the image and its load pulse
// assumes: go and ecc driven on sys_clk by the bench
`timescale 1ns/1ps
`default_nettype none
module nvm_engine_model import ident_regs_pkg::*; (
	input  wire logic                    sys_clk,
	input  wire logic                    go,
	input  wire logic                    ecc,
	output var  ident_regs_pkg::nvm_image_type img
);
	initial img = '0;
	always @(posedge sys_clk) begin
		img <= '{load: go, ecc_clean: ecc, lot0: 8'hA1, lot1: 8'hB2, default: '0};
	end
endmodule // nvm_engine_model
`default_nettype wire

//--- test/pmbus_ident_scratchpad_regs_bench.sv
// bench: register access sequences against the ident register bank
// assumes: package, design, model and checker compiled first
`timescale 1ns/1ps
`default_nettype none
module pmbus_ident_scratchpad_regs_bench;
	import ident_regs_pkg::*;
	localparam logic [15:0] ID = 16'h5A5A; // arbitrary value
	logic          sys_clk, resetn, page_sel, pec_required, go, ecc, pst;
	host_req_type  req;
	host_rsp_type  rsp;
	nvm_image_type img;
	int            n_fail, compares, cyc;
	nvm_engine_model nvm_u (.sys_clk(sys_clk), .go(go), .ecc(ecc), .img(img));
	pmbus_ident_scratchpad_regs #(.MAKER_ID(ID)) dut_u (.sys_clk(sys_clk), .resetn(resetn),
		.host_req(req), .page_sel(page_sel), .pec_required(pec_required),
		.nvm_image(img), .host_rsp(rsp), .pec_required_status(pst));
	initial begin
		sys_clk = 0;
		forever #10 sys_clk = ~sys_clk;
	end
	task automatic chk(string n, logic [17:0] s, logic [17:0] e);
		compares++;
		if (s !== e) begin
			n_fail++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic op(logic p, logic w, logic [7:0] c, logic [15:0] wd, logic [17:0] e);
		@(posedge sys_clk) req <= '{1'b1, w, c, wd};
		page_sel <= p;
		@(posedge sys_clk) req.valid <= 1'b0;
		#1 chk($sformatf("code %h", c), {rsp.valid, rsp.hit, rsp.rdata}, e);
	endtask
	task end_sim;
		$display("compares %0d fails %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			n_fail++;
			end_sim();
		end
	end
	initial begin
		{resetn, page_sel, pec_required, go, ecc} = '0;
		req = '0;
		repeat (16) @(posedge sys_clk);
		resetn <= 1'b1;
		op(0, 1, CMD_BUS_FEATURE, 16'hFFFF, 18'h300B0);
		op(0, 0, CMD_PROTOCOL_REV, 0, 18'h30011);
		op(0, 0, CMD_MAKER_ID, 0, {2'h3, ID});
		op(0, 0, CMD_MAKER_INFO, 0, 18'h30020);
		op(0, 0, 8'h00, 0, 18'h20000);
		$display("test fixed done");
		@(posedge sys_clk) go <= 1'b1;
		@(posedge sys_clk) go <= 1'b0;
		op(0, 0, CMD_MAKER_INFO, 0, 18'h30000);
		op(0, 0, CMD_FACTORY_LOT, 0, 18'h300A1);
		op(1, 1, CMD_FACTORY_LOT, 16'h0001, 18'h300B2);
		$display("test nvm done");
		op(0, 1, CMD_SCRATCH_PAGED, 16'h1234, 18'h30000);
		op(1, 1, CMD_SCRATCH_PAGED, 16'hABCD, 18'h30000);
		op(0, 0, CMD_SCRATCH_PAGED, 0, 18'h31234);
		op(1, 0, CMD_SCRATCH_PAGED, 0, 18'h3ABCD);
		op(0, 1, CMD_SCRATCH_UNPAGED, 16'h5555, 18'h30000);
		op(1, 0, CMD_SCRATCH_UNPAGED, 0, 18'h35555);
		op(0, 1, CMD_TOOL_WORD_B, 16'h00F0, 18'h30000);
		op(1, 0, CMD_TOOL_WORD_B, 0, 18'h30000);
		op(0, 1, CMD_TOOL_WORD_A, 16'h0F0F, 18'h30000);
		op(1, 0, CMD_TOOL_WORD_A, 0, 18'h30F0F);
		op(0, 1, CMD_OEM_WORD, 16'h2222, 18'h30000);
		op(1, 0, CMD_OEM_WORD, 0, 18'h32222);
		op(0, 1, CMD_MAKER_RSVD, 16'h3333, 18'h30000);
		op(1, 0, CMD_MAKER_RSVD, 0, 18'h30000);
		op(0, 0, CMD_MAKER_RSVD, 0, 18'h33333);
		@(posedge sys_clk) pec_required <= 1'b1;
		repeat (2) @(posedge sys_clk);
		#1 chk("pec status", {17'h0, pst}, 18'h1);
		$display("test rw done");
		end_sim();
	end
endmodule // pmbus_ident_scratchpad_regs_bench
`default_nettype wire
